// ### common/strap_cfg_pkg.sv
// Constants, types and strap decoding for the strap configuration decoder.
// Assumes strap pins arrive as level codes from the pin comparators.
// Operation
// - Read two four-level straps shared with link-status and LED pins.
// - Three strap pairs advertise all speeds; one adds extras, one power-down.
// - Other pairs advertise 10FD/100FD, 100FD, or force 10FD, 100HD, 100FD.
// - First five combinations enable autonegotiation; last three force speed.
// - Without power-down strap, attempt link immediately after reset.
// - With power-down strap, stay powered down until host clears the bit.
// - Host setting the power-down bit enters power-down at any time.
// - Host may override autoneg enable and advertised abilities.
// - Downspeed falls back to 10 after failed attempts at highest speed.
// - Host overrides downspeed enable bit and retry count field.
// - Energy-detect power-down enters low power when no energy seen.
// - EEE enabled and partner-advertised allows low power idle when idle.
// - Crossover strap: manual MDI, manual MDIX, auto prefer MDIX, auto prefer MDI.
// - Auto crossover resolves wiring itself; manual holds wiring fixed.
// - Auto crossover tries preferred wiring first.
// - Host overrides crossover via auto enable and manual crossed bits.
// - Interface straps select RGMII both delays, RGMII rx delay, MII, RMII.
// - Unstrapped interface pins default to RGMII with both delays.
// - Host reselects interface and clock delays through configuration registers.
package strap_cfg_pkg;

  // Four-level strap codes
  localparam logic [1:0] MODE_1 = 2'h0;
  localparam logic [1:0] MODE_2 = 2'h1;
  localparam logic [1:0] MODE_3 = 2'h2;
  localparam logic [1:0] MODE_4 = 2'h3;

  // Register offsets
  localparam logic [15:0] BASIC_CONTROL_ADDR    = 16'h0000;
  localparam logic [15:0] AUTONEG_ADVERTISEMENT_ADDR      = 16'h0004;
  localparam logic [15:0] PHY_CONTROL_ONE_ADDR  = 16'h0012;
  localparam logic [15:0] PHY_CONTROL_TWO_ADDR  = 16'h0016;
  localparam logic [15:0] PHY_CONTROL_THREE_ADDR = 16'h0017;
  localparam logic [15:0] RGMII_CONFIG_ADDR     = 16'hff23;
  localparam logic [15:0] REDUCED_IF_CONFIG_ADDR = 16'hff24;

  // Field positions
  localparam int BC_SPEED_BIT   = 13;
  localparam int BC_AUTONEG_BIT = 12;
  localparam int BC_PD_BIT      = 11;
  localparam int BC_DUPLEX_BIT  = 8;
  localparam int ADV_LO_BIT     = 5;
  localparam int ADV_HI_BIT     = 8;
  localparam int AUTO_XOVER_BIT = 10;
  localparam int MAN_CROSSED_BIT = 9;
  localparam int FALLBACK_BIT   = 10;
  localparam int RETRY_LO_BIT   = 10;
  localparam int RETRY_HI_BIT   = 12;
  localparam int RGMII_EN_BIT   = 0;
  localparam int TX_DLY_BIT     = 1;
  localparam int RX_DLY_BIT     = 2;
  localparam int RMII_EN_BIT    = 0;

  // Writable masks and fixed fields
  localparam logic [15:0] BASIC_CONTROL_MASK = 16'h3900;
  localparam logic [15:0] AUTONEG_ADVERTISEMENT_MASK   = 16'h01e0;
  localparam logic [15:0] ADV_SELECTOR       = 16'h0001;
  localparam logic [15:0] CTRL_ONE_MASK      = 16'h0600;
  localparam logic [15:0] CTRL_TWO_MASK      = 16'h0400;
  localparam logic [15:0] CTRL_THREE_MASK    = 16'h1c00;
  localparam logic [15:0] RGMII_MASK         = 16'h0007;
  localparam logic [15:0] RMII_MASK          = 16'h0001;
  localparam logic [2:0]  DEFAULT_RETRY      = 3'h4;

  // Advertisement vector order: {100FD, 100HD, 10FD, 10HD}
  localparam logic [3:0] ADV_ALL      = 4'hf;
  localparam logic [3:0] ADV_FD_BOTH  = 4'ha;
  localparam logic [3:0] ADV_100FD    = 4'h8;
  localparam logic [3:0] ADV_NONE     = 4'h0;
  localparam logic [3:0] ADV_100_MASK = 4'hc;
  localparam logic [3:0] ADV_10_MASK  = 4'h3;

  // Host interface modes
  typedef enum logic [1:0] {
    IF_RGMII = 2'h0,
    IF_MII   = 2'h1,
    IF_RMII  = 2'h2
  } host_if_t;

  typedef struct packed {
    logic       autoneg;
    logic [3:0] adv;
    logic       speed100;
    logic       full_duplex;
    logic       pd_after_reset;
    logic       downspeed;
    logic       energy_detect_powerdown;
    logic       eee;
  } strap_cfg_t;

  typedef struct packed {
    logic [1:0] cfg_hi;
    logic [1:0] cfg_lo;
    logic [1:0] xover;
    logic       if_hi;
    logic       if_lo;
  } strap_pins_t;

  // Speed/duplex strap pair decode; unlisted pairs advertise everything
  function automatic strap_cfg_t decode_speed(input logic [1:0] hi, input logic [1:0] lo);
    strap_cfg_t c;
    c = '{autoneg: 1'b1, adv: ADV_ALL, speed100: 1'b1, full_duplex: 1'b1,
          pd_after_reset: 1'b0, downspeed: 1'b0, energy_detect_powerdown: 1'b0, eee: 1'b0};
    if (hi == MODE_4 && lo == MODE_4) begin
      c.downspeed = 1'b1;
      c.energy_detect_powerdown      = 1'b1;
      c.eee       = 1'b1;
    end else if (hi == MODE_3 && lo == MODE_4) begin
      c.pd_after_reset = 1'b1;
    end else if (hi == MODE_4 && lo == MODE_3) begin
      c.adv = ADV_FD_BOTH;
    end else if (hi == MODE_4 && lo == MODE_1) begin
      c.adv = ADV_100FD;
    end else if (hi == MODE_1 && lo == MODE_2) begin
      c.autoneg  = 1'b0;
      c.adv      = ADV_NONE;
      c.speed100 = 1'b0;
    end else if (hi == MODE_2 && lo == MODE_2) begin
      c.autoneg     = 1'b0;
      c.adv         = ADV_NONE;
      c.full_duplex = 1'b0;
    end else if (hi == MODE_3 && lo == MODE_3) begin
      c.autoneg = 1'b0;
      c.adv     = ADV_NONE;
    end
    return c;
  endfunction : decode_speed

endpackage : strap_cfg_pkg

// ### hw/phy_strap_config_decoder.sv
// Strap latch, configuration registers and mode resolution of the PHY.
// Assumes the management engine presents register accesses on the mgmt port.
`timescale 1ns/1ps
`default_nettype none
module phy_strap_config_decoder (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  // Shared strap and output pins
  input  wire logic [1:0] PHY_STRAP_HI_LEVEL,
  output var  logic       LINK_STATUS_OUT,
  output var  logic       LINK_STATUS_OE,
  input  wire logic [1:0] PHY_STRAP_LO_LEVEL,
  output var  logic       INDICATOR_OUT_ZERO,
  output var  logic       INDICATOR_OE,
  input  wire logic [1:0] CROSSOVER_STRAP_LEVEL,
  output var  logic       GENERAL_CLOCK_OUT,
  output var  logic       GENERAL_CLOCK_OE,
  input  wire logic       HOST_IF_STRAP_HI,
  input  wire logic       HOST_IF_STRAP_LO,
  output var  logic       HOST_IF_PINS_RELEASED,
  // Management register port
  input  wire logic [15:0] MGMT_ADDR,
  input  wire logic [15:0] MGMT_WDATA,
  input  wire logic        MGMT_WE,
  input  wire logic        MGMT_RE,
  output var  logic [15:0] MGMT_RDATA,
  output var  logic        MGMT_RVALID,
  // PHY core status
  input  wire logic       LINK_GOOD,
  input  wire logic       ATTEMPT_FAIL,
  input  wire logic       XOVER_TIMEOUT,
  input  wire logic       ENERGY_DETECT,
  input  wire logic       PARTNER_EEE,
  input  wire logic       TX_IDLE,
  input  wire logic       RX_IDLE,
  // Resolved configuration
  output var  logic       AUTONEG_EN,
  output var  logic [3:0] ADVERTISE,
  output var  logic       FORCE_SPEED_100,
  output var  logic       FORCE_FULL_DUPLEX,
  output var  logic       POWERED_DOWN,
  output var  logic       LINK_ATTEMPT,
  output var  logic       DOWNSPEED_ACTIVE,
  output var  logic       ENERGY_DETECT_POWERDOWN_LOW_POWER,
  output var  logic       EEE_LPI,
  output var  logic       CROSSOVER_AUTO,
  output var  logic       CROSSED_SEL,
  output var  logic [1:0] HOST_IF_MODE,
  output var  logic       RX_CLOCK_DELAY,
  output var  logic       TX_CLOCK_DELAY
);

  typedef enum logic [1:0] {
    ST_RESET  = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_RUN    = 2'b10
  } phase_t;

  phase_t phase_reg;
  phase_t phase_next;

  strap_cfg_pkg::strap_pins_t pins_raw;
  strap_cfg_pkg::strap_pins_t pins_flt;
  strap_cfg_pkg::strap_pins_t pins_reg;
  strap_cfg_pkg::strap_cfg_t  strap_dec;

  logic [15:0] basic_control_reg;
  logic [15:0] autoneg_advertisement_reg;
  logic [15:0] ctrl_one_reg;
  logic [15:0] ctrl_two_reg;
  logic [15:0] ctrl_three_reg;
  logic [15:0] rgmii_reg;
  logic [15:0] rmii_reg;
  logic        energy_detect_powerdown_en_reg;
  logic        eee_en_reg;
  logic [2:0]  fail_cnt_reg;
  logic        gclk_reg;

  assign pins_raw = '{cfg_hi: PHY_STRAP_HI_LEVEL, cfg_lo: PHY_STRAP_LO_LEVEL,
                      xover: CROSSOVER_STRAP_LEVEL, if_hi: HOST_IF_STRAP_HI,
                      if_lo: HOST_IF_STRAP_LO};

  strap_pin_filter #(
    .W ($bits(strap_cfg_pkg::strap_pins_t))
  ) u_pin_filter (
    .CLK   (CLK),
    .PIN   (pins_raw),
    .LEVEL (pins_flt)
  );

  // Phase sequencing
  always_comb begin
    unique case (phase_reg)
      ST_RESET:  phase_next = ST_SAMPLE;
      ST_SAMPLE: phase_next = ST_RUN;
      ST_RUN:    phase_next = ST_RUN;
      default:   phase_next = ST_RESET;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      phase_reg <= ST_RESET;
    end else begin
      phase_reg <= phase_next;
    end
  end

  wire latch_now = (phase_reg == ST_RESET) && !SYS_RST;
  wire running   = (phase_reg == ST_RUN);

  // Straps caught once, at the first edge after release
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pins_reg <= '0;
    end else if (latch_now) begin
      pins_reg <= pins_flt;
    end
  end

  assign strap_dec = strap_cfg_pkg::decode_speed(pins_reg.cfg_hi, pins_reg.cfg_lo);

  // Register defaults from the latched straps
  wire        xover_auto    = pins_reg.xover[1];
  wire        xover_crossed = (pins_reg.xover == strap_cfg_pkg::MODE_3) ||
                              (pins_reg.xover == strap_cfg_pkg::MODE_2);
  wire [15:0] bc_default    = (16'(strap_dec.speed100) << strap_cfg_pkg::BC_SPEED_BIT)
                            | (16'(strap_dec.autoneg) << strap_cfg_pkg::BC_AUTONEG_BIT)
                            | (16'(strap_dec.pd_after_reset) << strap_cfg_pkg::BC_PD_BIT)
                            | (16'(strap_dec.full_duplex) << strap_cfg_pkg::BC_DUPLEX_BIT);
  wire [15:0] adv_default   = (16'(strap_dec.adv) << strap_cfg_pkg::ADV_LO_BIT)
                            | strap_cfg_pkg::ADV_SELECTOR;
  wire [15:0] one_default   = (16'(xover_auto) << strap_cfg_pkg::AUTO_XOVER_BIT)
                            | (16'(xover_crossed) << strap_cfg_pkg::MAN_CROSSED_BIT);
  wire [15:0] two_default   = 16'(strap_dec.downspeed) << strap_cfg_pkg::FALLBACK_BIT;
  wire [15:0] three_default = 16'(strap_cfg_pkg::DEFAULT_RETRY) << strap_cfg_pkg::RETRY_LO_BIT;
  wire        strap_rmii    = pins_reg.if_hi && pins_reg.if_lo;
  wire        strap_rgmii   = !pins_reg.if_lo;
  wire [15:0] rgmii_default = (16'(strap_rgmii) << strap_cfg_pkg::RGMII_EN_BIT)
                            | (16'(strap_rgmii && !pins_reg.if_hi)
                               << strap_cfg_pkg::TX_DLY_BIT)
                            | (16'(strap_rgmii) << strap_cfg_pkg::RX_DLY_BIT);
  wire [15:0] rmii_default  = 16'(strap_rmii) << strap_cfg_pkg::RMII_EN_BIT;

  // Register write decode
  wire wr       = MGMT_WE && running;
  wire wr_bc    = wr && (MGMT_ADDR == strap_cfg_pkg::BASIC_CONTROL_ADDR);
  wire wr_adv   = wr && (MGMT_ADDR == strap_cfg_pkg::AUTONEG_ADVERTISEMENT_ADDR);
  wire wr_one   = wr && (MGMT_ADDR == strap_cfg_pkg::PHY_CONTROL_ONE_ADDR);
  wire wr_two   = wr && (MGMT_ADDR == strap_cfg_pkg::PHY_CONTROL_TWO_ADDR);
  wire wr_three = wr && (MGMT_ADDR == strap_cfg_pkg::PHY_CONTROL_THREE_ADDR);
  wire wr_rgmii = wr && (MGMT_ADDR == strap_cfg_pkg::RGMII_CONFIG_ADDR);
  wire wr_rmii  = wr && (MGMT_ADDR == strap_cfg_pkg::REDUCED_IF_CONFIG_ADDR);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      basic_control_reg <= '0;
      autoneg_advertisement_reg   <= '0;
      ctrl_one_reg      <= '0;
      ctrl_two_reg      <= '0;
      ctrl_three_reg    <= '0;
      rgmii_reg         <= '0;
      rmii_reg          <= '0;
      energy_detect_powerdown_en_reg       <= 1'b0;
      eee_en_reg        <= 1'b0;
    end else if (phase_reg == ST_SAMPLE) begin
      basic_control_reg <= bc_default;
      autoneg_advertisement_reg   <= adv_default;
      ctrl_one_reg      <= one_default;
      ctrl_two_reg      <= two_default;
      ctrl_three_reg    <= three_default;
      rgmii_reg         <= rgmii_default;
      rmii_reg          <= rmii_default;
      energy_detect_powerdown_en_reg       <= strap_dec.energy_detect_powerdown;
      eee_en_reg        <= strap_dec.eee;
    end else begin
      if (wr_bc) begin
        basic_control_reg <= MGMT_WDATA & strap_cfg_pkg::BASIC_CONTROL_MASK;
      end
      if (wr_adv) begin
        autoneg_advertisement_reg <= (MGMT_WDATA & strap_cfg_pkg::AUTONEG_ADVERTISEMENT_MASK)
                         | strap_cfg_pkg::ADV_SELECTOR;
      end
      if (wr_one) begin
        ctrl_one_reg <= MGMT_WDATA & strap_cfg_pkg::CTRL_ONE_MASK;
      end
      if (wr_two) begin
        ctrl_two_reg <= MGMT_WDATA & strap_cfg_pkg::CTRL_TWO_MASK;
      end
      if (wr_three) begin
        ctrl_three_reg <= MGMT_WDATA & strap_cfg_pkg::CTRL_THREE_MASK;
      end
      if (wr_rgmii) begin
        rgmii_reg <= MGMT_WDATA & strap_cfg_pkg::RGMII_MASK;
      end
      if (wr_rmii) begin
        rmii_reg <= MGMT_WDATA & strap_cfg_pkg::RMII_MASK;
      end
    end
  end

  // Register read path
  logic [15:0] rd_mux;
  always_comb begin
    unique case (MGMT_ADDR)
      strap_cfg_pkg::BASIC_CONTROL_ADDR:     rd_mux = basic_control_reg;
      strap_cfg_pkg::AUTONEG_ADVERTISEMENT_ADDR:       rd_mux = autoneg_advertisement_reg;
      strap_cfg_pkg::PHY_CONTROL_ONE_ADDR:   rd_mux = ctrl_one_reg;
      strap_cfg_pkg::PHY_CONTROL_TWO_ADDR:   rd_mux = ctrl_two_reg;
      strap_cfg_pkg::PHY_CONTROL_THREE_ADDR: rd_mux = ctrl_three_reg;
      strap_cfg_pkg::RGMII_CONFIG_ADDR:      rd_mux = rgmii_reg;
      strap_cfg_pkg::REDUCED_IF_CONFIG_ADDR: rd_mux = rmii_reg;
      default:                               rd_mux = '0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      MGMT_RDATA  <= '0;
      MGMT_RVALID <= 1'b0;
    end else begin
      MGMT_RDATA  <= (MGMT_RE && running) ? rd_mux : '0;
      MGMT_RVALID <= MGMT_RE && running;
    end
  end

  // Effective configuration
  wire       pd_bit      = basic_control_reg[strap_cfg_pkg::BC_PD_BIT];
  wire       an_bit      = basic_control_reg[strap_cfg_pkg::BC_AUTONEG_BIT];
  wire [3:0] adv_bits    = autoneg_advertisement_reg[strap_cfg_pkg::ADV_HI_BIT:strap_cfg_pkg::ADV_LO_BIT];
  wire       attempt     = running && !pd_bit;
  wire       multi_speed = |(adv_bits & strap_cfg_pkg::ADV_100_MASK)
                        && |(adv_bits & strap_cfg_pkg::ADV_10_MASK);
  wire       fallback_en = ctrl_two_reg[strap_cfg_pkg::FALLBACK_BIT];
  wire [2:0] retry_lim   = ctrl_three_reg[strap_cfg_pkg::RETRY_HI_BIT:strap_cfg_pkg::RETRY_LO_BIT];
  wire       ds_arm      = attempt && an_bit && multi_speed && fallback_en;
  wire [2:0] fail_inc    = fail_cnt_reg + 3'h1;
  wire       auto_x      = ctrl_one_reg[strap_cfg_pkg::AUTO_XOVER_BIT];
  wire       man_x       = ctrl_one_reg[strap_cfg_pkg::MAN_CROSSED_BIT];
  wire       rmii_sel    = rmii_reg[strap_cfg_pkg::RMII_EN_BIT];
  wire       rgmii_sel   = rgmii_reg[strap_cfg_pkg::RGMII_EN_BIT] && !rmii_sel;

  // Downspeed: count failed attempts at the highest advertised speed
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      fail_cnt_reg     <= '0;
      DOWNSPEED_ACTIVE <= 1'b0;
    end else if (!ds_arm) begin
      fail_cnt_reg     <= '0;
      DOWNSPEED_ACTIVE <= 1'b0;
    end else if (ATTEMPT_FAIL && !DOWNSPEED_ACTIVE && !LINK_GOOD) begin
      fail_cnt_reg <= fail_inc;
      if (fail_inc >= retry_lim) begin
        DOWNSPEED_ACTIVE <= 1'b1;
      end
    end
  end

  // Crossover: preference reloaded as attempts begin, toggle on each timeout while LINK_GOOD is low
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      CROSSED_SEL <= 1'b0;
    end else if (!auto_x || !attempt || !LINK_ATTEMPT) begin
      CROSSED_SEL <= man_x;
    end else if (XOVER_TIMEOUT && !LINK_GOOD) begin
      CROSSED_SEL <= !CROSSED_SEL;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      AUTONEG_EN        <= 1'b0;
      ADVERTISE         <= '0;
      FORCE_SPEED_100   <= 1'b0;
      FORCE_FULL_DUPLEX <= 1'b0;
      POWERED_DOWN      <= 1'b1;
      LINK_ATTEMPT      <= 1'b0;
      ENERGY_DETECT_POWERDOWN_LOW_POWER    <= 1'b0;
      EEE_LPI           <= 1'b0;
      CROSSOVER_AUTO    <= 1'b0;
      HOST_IF_MODE      <= strap_cfg_pkg::IF_RGMII;
      RX_CLOCK_DELAY    <= 1'b0;
      TX_CLOCK_DELAY    <= 1'b0;
    end else begin
      AUTONEG_EN        <= an_bit;
      ADVERTISE         <= DOWNSPEED_ACTIVE ? (adv_bits & strap_cfg_pkg::ADV_10_MASK)
                                            : adv_bits;
      FORCE_SPEED_100   <= basic_control_reg[strap_cfg_pkg::BC_SPEED_BIT];
      FORCE_FULL_DUPLEX <= basic_control_reg[strap_cfg_pkg::BC_DUPLEX_BIT];
      POWERED_DOWN      <= !attempt;
      LINK_ATTEMPT      <= attempt;
      ENERGY_DETECT_POWERDOWN_LOW_POWER    <= attempt && energy_detect_powerdown_en_reg && !ENERGY_DETECT;
      EEE_LPI           <= attempt && eee_en_reg && PARTNER_EEE && LINK_GOOD
                        && TX_IDLE && RX_IDLE;
      CROSSOVER_AUTO    <= auto_x;
      HOST_IF_MODE      <= rmii_sel  ? strap_cfg_pkg::IF_RMII
                         : rgmii_sel ? strap_cfg_pkg::IF_RGMII
                                     : strap_cfg_pkg::IF_MII;
      RX_CLOCK_DELAY    <= rgmii_sel && rgmii_reg[strap_cfg_pkg::RX_DLY_BIT];
      TX_CLOCK_DELAY    <= rgmii_sel && rgmii_reg[strap_cfg_pkg::TX_DLY_BIT];
    end
  end

  // Shared pins return to their output functions once straps are caught
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      LINK_STATUS_OUT       <= 1'b0;
      LINK_STATUS_OE        <= 1'b0;
      INDICATOR_OUT_ZERO    <= 1'b0;
      INDICATOR_OE          <= 1'b0;
      GENERAL_CLOCK_OUT     <= 1'b0;
      GENERAL_CLOCK_OE      <= 1'b0;
      HOST_IF_PINS_RELEASED <= 1'b0;
      gclk_reg              <= 1'b0;
    end else begin
      gclk_reg              <= !gclk_reg;
      LINK_STATUS_OUT       <= attempt && LINK_GOOD;
      LINK_STATUS_OE        <= running;
      INDICATOR_OUT_ZERO    <= attempt && LINK_GOOD && !(TX_IDLE && RX_IDLE);
      INDICATOR_OE          <= running;
      GENERAL_CLOCK_OUT     <= running && gclk_reg;
      GENERAL_CLOCK_OE      <= running;
      HOST_IF_PINS_RELEASED <= running;
    end
  end

endmodule : phy_strap_config_decoder
`default_nettype wire

// ### hw/strap_pin_filter.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes pins are asynchronous to CLK; output updates only when the last two stages agree.
`timescale 1ns/1ps
`default_nettype none
module strap_pin_filter #(
  parameter int W = 1
) (
  // Clock
  input  wire logic         CLK,
  // Pin and filtered level
  input  wire logic [W-1:0] PIN,
  output var  logic [W-1:0] LEVEL
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] hold_reg;
  wire          agree = (sync_reg == hold_reg);

  // Data path only; strap capture must see pins while reset is held
  always_ff @(posedge CLK) begin
    meta_reg <= PIN;
    sync_reg <= meta_reg;
    hold_reg <= sync_reg;
  end

  always_ff @(posedge CLK) begin
    if (agree) begin
      LEVEL <= hold_reg;
    end
  end

endmodule : strap_pin_filter
`default_nettype wire

// ### verification/strap_board_model.sv
// Board strap resistors seen by the decoder's pin comparators.
// Assumes the setting is held steady across each hardware reset.
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
  // Resistor setting
  input  wire strap_cfg_pkg::strap_pins_t CFG,
  input  wire logic                       OPEN_IF,
  // Pin levels
  output var  logic [1:0] PHY_STRAP_HI_LEVEL, PHY_STRAP_LO_LEVEL, CROSSOVER_STRAP_LEVEL,
  output var  logic       HOST_IF_STRAP_HI, HOST_IF_STRAP_LO
);
  assign PHY_STRAP_HI_LEVEL    = CFG.cfg_hi;
  assign PHY_STRAP_LO_LEVEL    = CFG.cfg_lo;
  // Preference chosen to suit the far PHY and the cable wiring
  assign CROSSOVER_STRAP_LEVEL = CFG.xover;
  // Weak pull-downs win on unstrapped pins
  assign HOST_IF_STRAP_HI      = OPEN_IF ? 1'b0 : CFG.if_hi;
  assign HOST_IF_STRAP_LO      = OPEN_IF ? 1'b0 : CFG.if_lo;
endmodule : strap_board_model
`default_nettype wire

// ### verification/strap_cfg_checker.sv
// Port assertions for the strap configuration decoder.
// Assumes one clock domain and the synchronous reset of the decoder.
`timescale 1ns/1ps
`default_nettype none
module strap_cfg_checker (
  // Clock and reset
  input wire logic        CLK, SYS_RST,
  // Management writes
  input wire logic [15:0] MGMT_ADDR, MGMT_WDATA,
  input wire logic        MGMT_WE,
  // Core status
  input wire logic        LINK_GOOD, XOVER_TIMEOUT, ENERGY_DETECT,
  input wire logic        PARTNER_EEE, TX_IDLE, RX_IDLE,
  // Resolved configuration
  input wire logic        POWERED_DOWN, LINK_ATTEMPT, DOWNSPEED_ACTIVE,
  input wire logic        ENERGY_DETECT_POWERDOWN_LOW_POWER, EEE_LPI, CROSSOVER_AUTO, CROSSED_SEL,
  input wire logic        LINK_STATUS_OE, RX_CLOCK_DELAY, TX_CLOCK_DELAY,
  input wire logic [3:0]  ADVERTISE,
  input wire logic [1:0]  HOST_IF_MODE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_attempt_vs_pd: assert property (LINK_ATTEMPT != POWERED_DOWN)
    else $error("attempt and power-down disagree");
  a_pd_write: assert property (MGMT_WE && MGMT_ADDR == 16'h0000
    && MGMT_WDATA[11] && LINK_ATTEMPT |=> ##1 POWERED_DOWN) else $error("no power-down");
  a_energy_detect_powerdown_cause: assert property (ENERGY_DETECT_POWERDOWN_LOW_POWER
    |-> !$past(ENERGY_DETECT) && LINK_ATTEMPT) else $error("low power with energy");
  a_lpi_cause: assert property (EEE_LPI |-> $past(PARTNER_EEE) && $past(LINK_GOOD)
    && $past(TX_IDLE) && $past(RX_IDLE)) else $error("idle entered while busy");
  a_xover_toggle: assert property (XOVER_TIMEOUT && !LINK_GOOD && CROSSOVER_AUTO
    && LINK_ATTEMPT && !MGMT_WE |=> CROSSED_SEL != $past(CROSSED_SEL)) else $error("no toggle");
  a_manual_fixed: assert property (!CROSSOVER_AUTO && !$past(CROSSOVER_AUTO)
    && !$past(MGMT_WE) && !$past(MGMT_WE, 2) && $past(LINK_ATTEMPT, 3) |-> $stable(CROSSED_SEL))
    else $error("manual wiring moved");
  a_fallback_adv: assert property (DOWNSPEED_ACTIVE && $past(DOWNSPEED_ACTIVE)
    |-> (ADVERTISE & 4'hc) == 4'h0) else $error("100 still advertised");
  a_delay_rgmii: assert property (HOST_IF_MODE != strap_cfg_pkg::IF_RGMII
    |-> !RX_CLOCK_DELAY && !TX_CLOCK_DELAY) else $error("delay outside RGMII");
  a_oe_release: assert property ($rose(LINK_STATUS_OE) |-> !$past(SYS_RST, 2))
    else $error("pin driven too early");
  c_energy_detect_powerdown: cover property (ENERGY_DETECT_POWERDOWN_LOW_POWER);
  c_lpi: cover property (EEE_LPI);
  c_fallback: cover property (DOWNSPEED_ACTIVE);
endmodule : strap_cfg_checker
bind phy_strap_config_decoder strap_cfg_checker chk (.*);
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the strap configuration decoder.
// Assumes board straps from the board model and direct register strobes.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        CLK, SYS_RST, MGMT_WE, MGMT_RE, LINK_GOOD, ATTEMPT_FAIL, XOVER_TIMEOUT;
  logic        ENERGY_DETECT, PARTNER_EEE, TX_IDLE, RX_IDLE, open_if;
  logic [15:0] MGMT_ADDR, MGMT_WDATA;
  strap_cfg_pkg::strap_pins_t pins;
  wire  [15:0] MGMT_RDATA;
  wire  [3:0]  ADVERTISE;
  wire  [1:0]  PHY_STRAP_HI_LEVEL, PHY_STRAP_LO_LEVEL, CROSSOVER_STRAP_LEVEL, HOST_IF_MODE;
  wire         HOST_IF_STRAP_HI, HOST_IF_STRAP_LO, LINK_STATUS_OUT, LINK_STATUS_OE;
  wire         INDICATOR_OUT_ZERO, INDICATOR_OE, GENERAL_CLOCK_OUT, GENERAL_CLOCK_OE;
  wire         HOST_IF_PINS_RELEASED, MGMT_RVALID, AUTONEG_EN, FORCE_SPEED_100, LINK_ATTEMPT;
  wire         FORCE_FULL_DUPLEX, POWERED_DOWN, DOWNSPEED_ACTIVE, ENERGY_DETECT_POWERDOWN_LOW_POWER, EEE_LPI;
  wire         CROSSOVER_AUTO, CROSSED_SEL, RX_CLOCK_DELAY, TX_CLOCK_DELAY;
  wire  [15:0] cfg_view = {2'h0, AUTONEG_EN, ADVERTISE, FORCE_SPEED_100, FORCE_FULL_DUPLEX,
    POWERED_DOWN, CROSSOVER_AUTO, CROSSED_SEL, HOST_IF_MODE, RX_CLOCK_DELAY, TX_CLOCK_DELAY};
  int          num_errors = 0;
  int          cmp_count = 0;
  // Strap pins, then expected configuration view
  logic [23:0] rows [8] = '{24'hf03f83, 24'h363f92, 24'hb93ff4, 24'hef35a8,
                            24'hc03183, 24'h160092, 24'h590134, 24'haf01a8};

  phy_strap_config_decoder dut (.*);
  strap_board_model board (.*, .CFG(pins), .OPEN_IF(open_if));

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : tick

  task automatic rst(input logic [7:0] p, input logic o);
    @(posedge CLK);
    SYS_RST <= 1'b1;
    pins    <= p;
    open_if <= o;
    repeat (8) @(posedge CLK);
    chk({LINK_STATUS_OE, INDICATOR_OE, GENERAL_CLOCK_OE, POWERED_DOWN}, 4'h1);
    SYS_RST <= 1'b0;
    tick(4);
  endtask : rst

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge CLK);
    MGMT_ADDR  <= a;
    MGMT_WDATA <= d;
    MGMT_WE    <= 1'b1;
    @(posedge CLK);
    MGMT_WE <= 1'b0;
    tick(3);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge CLK);
    MGMT_ADDR <= a;
    MGMT_RE   <= 1'b1;
    @(posedge CLK);
    MGMT_RE <= 1'b0;
    #1;
    chk(MGMT_RVALID, 1'b1);
    chk(MGMT_RDATA, exp);
  endtask : rd

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  initial begin
    #100us;
    num_errors++;
    conclude();
  end

  initial begin
    SYS_RST = 1'b1;
    pins = 8'hf0;
    {MGMT_WE, MGMT_RE, LINK_GOOD, ATTEMPT_FAIL, XOVER_TIMEOUT, open_if} = '0;
    {PARTNER_EEE, TX_IDLE, RX_IDLE, MGMT_ADDR, MGMT_WDATA} = '0;
    ENERGY_DETECT = 1'b1;
    foreach (rows[i]) begin
      rst(rows[i][23:16], 1'b0);
      chk(cfg_view, rows[i][15:0]);
      chk(LINK_ATTEMPT, !rows[i][6]);
      chk({LINK_STATUS_OE, INDICATOR_OE, GENERAL_CLOCK_OE, HOST_IF_PINS_RELEASED}, 4'hf);
      chk({LINK_STATUS_OUT, INDICATOR_OUT_ZERO, GENERAL_CLOCK_OUT}, 3'h1);
      tick(1);
      chk(GENERAL_CLOCK_OUT, 1'b0);
    end
    $display("strap table done");
    rst(8'hf8, 1'b1);
    chk(cfg_view, 16'h3fb3);
    @(posedge CLK) pins <= 8'haf;
    tick(10);
    chk(cfg_view, 16'h3fb3);
    @(posedge CLK) ENERGY_DETECT <= 1'b0;
    tick(3);
    chk(ENERGY_DETECT_POWERDOWN_LOW_POWER, 1'b1);
    @(posedge CLK) {ENERGY_DETECT, LINK_GOOD, PARTNER_EEE, TX_IDLE, RX_IDLE} <= 5'h1f;
    tick(3);
    chk({ENERGY_DETECT_POWERDOWN_LOW_POWER, EEE_LPI}, 2'h1);
    chk({LINK_STATUS_OUT, INDICATOR_OUT_ZERO}, 2'h2);
    @(posedge CLK) TX_IDLE <= 1'b0;
    tick(3);
    chk(EEE_LPI, 1'b0);
    chk({LINK_STATUS_OUT, INDICATOR_OUT_ZERO}, 2'h3);
    @(posedge CLK) {LINK_GOOD, XOVER_TIMEOUT} <= 2'h1;
    @(posedge CLK) XOVER_TIMEOUT <= 1'b0;
    tick(3);
    chk(CROSSED_SEL, 1'b0);
    $display("low power and crossover done");
    wr(16'h0017, 16'h0800);
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK) ATTEMPT_FAIL <= 1'b1;
      @(posedge CLK) ATTEMPT_FAIL <= 1'b0;
      tick(3);
      chk({DOWNSPEED_ACTIVE, ADVERTISE}, {i == 1, i == 1 ? 4'h3 : 4'hf});
    end
    wr(16'h0016, 16'h0000);
    chk({DOWNSPEED_ACTIVE, ADVERTISE}, 5'h0f);
    wr(16'h0004, 16'h0100);
    chk(ADVERTISE, 4'h8);
    rd(16'h0004, 16'h0101);
    wr(16'h0000, 16'h2900);
    chk({POWERED_DOWN, LINK_ATTEMPT, AUTONEG_EN}, 3'h4);
    rd(16'h0000, 16'h2900);
    wr(16'hff23, 16'h0005);
    chk({HOST_IF_MODE, RX_CLOCK_DELAY, TX_CLOCK_DELAY}, 4'h2);
    wr(16'h0012, 16'h0200);
    chk({CROSSOVER_AUTO, CROSSED_SEL}, 2'h1);
    rd(16'h0033, 16'h0000);
    wr(16'h0000, 16'h3100);
    chk({POWERED_DOWN, LINK_ATTEMPT}, 2'h1);
    $display("register overrides done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
